// *** sipc_defs.svh ***
// register map, field positions, reset values and peripheral indices
`ifndef SIPC_DEFS_SVH
`define SIPC_DEFS_SVH

`define SIPC_AW        8
`define SIPC_DW        32
`define SIPC_OFF_CLK   8'h00
`define SIPC_OFF_MODE  8'h04
`define SIPC_OFF_CTRL  8'h08
`define SIPC_OFF_SRC   8'h0c
`define SIPC_OFF_STAT  8'h10
`define SIPC_RD_ZERO   32'h0000_0000
`define SIPC_CTL_RST   1'h0
`define SIPC_CLK_SUB   0
`define SIPC_CLK_STOP  1
`define SIPC_MODE_KIND 0
`define SIPC_CTRL_TRIG 0
`define SIPC_ST_MAIN   2
`define SIPC_ST_EN     8
`define SIPC_BYTE_W    8
`define SIPC_SRC_W     13
`define SIPC_SRC_RST   13'h0000
`define SIPC_S_T16W    0
`define SIPC_S_WSUB    1
`define SIPC_S_T8A_EXT 2
`define SIPC_S_T8A_T16 3
`define SIPC_S_T8B_EXT 4
`define SIPC_S_T8B_T16 5
`define SIPC_S_HLDB    6
`define SIPC_S_WDT2    7
`define SIPC_S_CSIA    8
`define SIPC_S_CSIB    9
`define SIPC_S_UARTA   10
`define SIPC_S_RTOTRG  11
`define SIPC_S_RTOSEL  12
`define SIPC_NP        18
`define SIPC_EN_RST    18'h0_0000
`define SIPC_P_IRQ     0
`define SIPC_P_PULSE   1
`define SIPC_P_T16     2
`define SIPC_P_T8A     3
`define SIPC_P_T8B     4
`define SIPC_P_HLDA    5
`define SIPC_P_HLDB    6
`define SIPC_P_WATCH   7
`define SIPC_P_WDT1    8
`define SIPC_P_WDT2    9
`define SIPC_P_CSIA    10
`define SIPC_P_CSIB    11
`define SIPC_P_TWS     12
`define SIPC_P_UARTA   13
`define SIPC_P_UARTB   14
`define SIPC_P_KEY     15
`define SIPC_P_ADC     16
`define SIPC_P_RTO     17

`endif

// *** sipc_pkg.sv ***
// shared types of the subclock idle power controller
`default_nettype none

package sipc_pkg;
    typedef enum logic [1:0] {
        SIPC_NORMAL,
        SIPC_SUBCLK,
        SIPC_SUB_IDLE
    } sipc_mode_t;
endpackage

`default_nettype wire

// *** sipc_gate.sv ***
// per-peripheral clock gating from operating mode and clock sources
`default_nettype none
`include "sipc_defs.svh"

module sipc_gate import sipc_pkg::*; (
    input  wire logic                   clk_in,
    input  wire logic                   resetn_in,
    input  wire sipc_mode_t             mode_in,
    input  wire logic                   main_run_in,
    input  wire logic [`SIPC_SRC_W-1:0] src_in,
    output var  logic [`SIPC_NP-1:0]    en_out
);
    logic                stopped;
    logic                t16_ok;
    logic [`SIPC_NP-1:0] ok_full;
    logic [`SIPC_NP-1:0] ok_sub;
    logic [`SIPC_NP-1:0] ok_stop;
    logic [`SIPC_NP-1:0] ok_idle;

    assign stopped = !main_run_in && (mode_in != SIPC_NORMAL);
    // main clock stopped: only subclock or pin clocked units run
    assign t16_ok = src_in[`SIPC_S_T16W] &&
                    (main_run_in || src_in[`SIPC_S_WSUB]);

    always_comb begin
        ok_full = {`SIPC_NP{1'h1}};
        ok_sub = ok_full;
        ok_sub[`SIPC_P_WDT1] = 1'h0;
        ok_stop = '0;
        ok_stop[`SIPC_P_IRQ] = 1'h1;
        ok_stop[`SIPC_P_KEY] = 1'h1;
        ok_stop[`SIPC_P_T16] = t16_ok;
        ok_stop[`SIPC_P_T8A] = src_in[`SIPC_S_T8A_EXT] ||
            (src_in[`SIPC_S_T8A_T16] && t16_ok);
        ok_stop[`SIPC_P_T8B] = src_in[`SIPC_S_T8B_EXT] ||
            (src_in[`SIPC_S_T8B_T16] && t16_ok);
        ok_stop[`SIPC_P_WATCH] = src_in[`SIPC_S_WSUB];
        ok_stop[`SIPC_P_HLDB] = src_in[`SIPC_S_HLDB];
        ok_stop[`SIPC_P_WDT2] = src_in[`SIPC_S_WDT2];
        ok_stop[`SIPC_P_CSIA] = src_in[`SIPC_S_CSIA];
        ok_stop[`SIPC_P_CSIB] = src_in[`SIPC_S_CSIB];
        ok_stop[`SIPC_P_UARTA] = src_in[`SIPC_S_UARTA];
        ok_stop[`SIPC_P_RTO] = src_in[`SIPC_S_RTOTRG] &&
            (src_in[`SIPC_S_RTOSEL] ? src_in[`SIPC_S_T8B_EXT]
                                    : src_in[`SIPC_S_T8A_EXT]);
        // idle stops the interrupt controller as well
        ok_idle = ok_stop;
        ok_idle[`SIPC_P_IRQ] = 1'h0;
        if (main_run_in) begin
            ok_idle[`SIPC_P_WATCH] = 1'h1;
        end
    end

    for (genvar i = 0; i < `SIPC_NP; i++) begin : g_en
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                en_out[i] <= `SIPC_CTL_RST;
            end else if (mode_in == SIPC_SUB_IDLE) begin
                en_out[i] <= ok_idle[i];
            end else if (mode_in == SIPC_SUBCLK) begin
                en_out[i] <= main_run_in ? ok_sub[i] : ok_stop[i];
            end else begin
                en_out[i] <= ok_full[i];
            end
        end
    end

    t16_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && !(src_in[`SIPC_S_T16W] && src_in[`SIPC_S_WSUB])
        |=> !en_out[`SIPC_P_T16])
        else $error("16-bit timer runs without watch clock source");
    t8_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && !src_in[`SIPC_S_T8A_EXT] &&
        !(src_in[`SIPC_S_T8A_T16] && t16_ok) |=> !en_out[`SIPC_P_T8A])
        else $error("8-bit timer runs without valid clock");
    sub_count_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && !src_in[`SIPC_S_WDT2] && !src_in[`SIPC_S_HLDB]
        |=> !en_out[`SIPC_P_WDT2] && !en_out[`SIPC_P_HLDB])
        else $error("subclock counter runs on main clock source");
    csi_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && !src_in[`SIPC_S_CSIA] |=> !en_out[`SIPC_P_CSIA])
        else $error("clocked serial runs without pin clock");
    uart_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && (mode_in == SIPC_SUBCLK) && src_in[`SIPC_S_UARTA]
        |=> en_out[`SIPC_P_UARTA] && !en_out[`SIPC_P_UARTB])
        else $error("async serial gating wrong");
    rto_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stopped && !src_in[`SIPC_S_RTOTRG] |=> !en_out[`SIPC_P_RTO])
        else $error("real-time output runs without timer trigger");
endmodule

`default_nettype wire

// *** sipc_top.sv ***
// subclock idle power controller with avalon-mm register slave
`default_nettype none
`include "sipc_defs.svh"

// Functional notes
// - idle is entered only from subclock mode, with idle kind 0 and the trigger written 1.
// - in idle the oscillators run but the cpu clock and the main clocked peripheral clocks are cut.
// - in idle execution halts and ram and control state stay untouched.
// - in idle only subclock or pin clocked peripherals keep running, and the watch too while main runs.
// - main stopped: 16-bit timer counts only on watch irq with watch on subclock.
// - main stopped: 8-bit timers run only on pin clock or an enabled 16-bit match.
// - main stopped: watch, hold timer b and watchdog 2 need the subclock.
// - main stopped: clocked serial channels need their pin clock.
// - main stopped: async serial a needs its external baud pin.
// - main stopped: real-time output needs a pin clocked 8-bit timer trigger.
// - subclock select moves the system clock; main stop then halts the main osc.
// - an interrupt leaves idle to subclock mode, a reset to normal mode.

module sipc_top import sipc_pkg::*; #(
    parameter int WAKE_SRCS = 8
) (
    input  wire logic                  CLK_IN,
    input  wire logic                  RESETN_IN,
    input  wire logic [`SIPC_AW-1:0]   AVS_ADDRESS_IN,
    input  wire logic                  AVS_READ_IN,
    input  wire logic                  AVS_WRITE_IN,
    input  wire logic [`SIPC_DW-1:0]   AVS_WRITEDATA_IN,
    input  wire logic [3:0]            AVS_BYTEENABLE_IN,
    input  wire logic [WAKE_SRCS-1:0]  WAKE_REQ_IN,
    output var  logic [`SIPC_DW-1:0]   AVS_READDATA_OUT,
    output var  logic                  AVS_WAITREQUEST_OUT,
    output var  logic                  CPU_CLK_EN_OUT,
    output var  logic                  SYS_CLK_SUB_OUT,
    output var  logic                  MAIN_OSC_EN_OUT,
    output var  logic                  RAM_HOLD_OUT,
    output var  logic [`SIPC_NP-1:0]   PERIPH_EN_OUT,
    output var  logic [1:0]            MODE_OUT
);
    if (WAKE_SRCS < 1 || WAKE_SRCS > 32) begin : g_chk
        $error("WAKE_SRCS must lie between 1 and 32");
    end

    logic                   req;
    logic                   wr_take;
    logic                   wr_ok;
    logic                   trig;
    logic                   wake;
    logic [`SIPC_DW-1:0]    rd_val;
    logic                   clk_sub;
    logic                   osc_stop;
    logic                   idle_kind;
    logic [`SIPC_SRC_W-1:0] src;
    sipc_mode_t             mode;
    sipc_mode_t             next_mode;

    // bus handshake

    assign req = AVS_READ_IN || AVS_WRITE_IN;
    // a write lands only on the edge where waitrequest is seen low
    assign wr_take = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
    // the cpu is halted in idle, so stores then are dropped
    assign wr_ok = wr_take && (mode != SIPC_SUB_IDLE);
    assign wake = |WAKE_REQ_IN;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            AVS_WAITREQUEST_OUT <= 1'h1;
        end else begin
            AVS_WAITREQUEST_OUT <= !(req && AVS_WAITREQUEST_OUT);
        end
    end

    always_comb begin
        rd_val = `SIPC_RD_ZERO;
        case (AVS_ADDRESS_IN)
            `SIPC_OFF_CLK: begin
                rd_val[`SIPC_CLK_SUB] = clk_sub;
                rd_val[`SIPC_CLK_STOP] = osc_stop;
            end
            `SIPC_OFF_MODE: begin
                rd_val[`SIPC_MODE_KIND] = idle_kind;
            end
            `SIPC_OFF_SRC: begin
                rd_val[`SIPC_SRC_W-1:0] = src;
            end
            `SIPC_OFF_STAT: begin
                rd_val[1:0] = mode;
                rd_val[`SIPC_ST_MAIN] = MAIN_OSC_EN_OUT;
                rd_val[`SIPC_ST_EN +: `SIPC_NP] = PERIPH_EN_OUT;
            end
            default: begin
                rd_val = `SIPC_RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            AVS_READDATA_OUT <= `SIPC_RD_ZERO;
        end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
            AVS_READDATA_OUT <= rd_val;
        end
    end

    // clock control register

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            clk_sub <= `SIPC_CTL_RST;
            osc_stop <= `SIPC_CTL_RST;
        end else if (wr_ok && AVS_BYTEENABLE_IN[0] &&
                     AVS_ADDRESS_IN == `SIPC_OFF_CLK) begin
            // main osc may stop only on subclock, and subclock
            // cannot be left while the main osc stays stopped
            clk_sub <= AVS_WRITEDATA_IN[`SIPC_CLK_SUB] ||
                (clk_sub && AVS_WRITEDATA_IN[`SIPC_CLK_STOP]);
            osc_stop <= AVS_WRITEDATA_IN[`SIPC_CLK_STOP] &&
                (AVS_WRITEDATA_IN[`SIPC_CLK_SUB] || clk_sub);
        end
    end

    // idle kind register

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            idle_kind <= `SIPC_CTL_RST;
        end else if (wr_ok && AVS_BYTEENABLE_IN[0] &&
                     AVS_ADDRESS_IN == `SIPC_OFF_MODE) begin
            idle_kind <= AVS_WRITEDATA_IN[`SIPC_MODE_KIND];
        end
    end

    // clock source selections of the peripherals

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            src <= `SIPC_SRC_RST;
        end else if (wr_ok && AVS_ADDRESS_IN == `SIPC_OFF_SRC) begin
            if (AVS_BYTEENABLE_IN[0]) begin
                src[`SIPC_BYTE_W-1:0] <= AVS_WRITEDATA_IN[`SIPC_BYTE_W-1:0];
            end
            if (AVS_BYTEENABLE_IN[1]) begin
                src[`SIPC_SRC_W-1:`SIPC_BYTE_W] <=
                    AVS_WRITEDATA_IN[`SIPC_SRC_W-1:`SIPC_BYTE_W];
            end
        end
    end

    // standby trigger is write-only and self-clearing
    assign trig = wr_ok && AVS_BYTEENABLE_IN[0] &&
                  AVS_ADDRESS_IN == `SIPC_OFF_CTRL &&
                  AVS_WRITEDATA_IN[`SIPC_CTRL_TRIG];

    // mode sequencing

    always_comb begin
        next_mode = mode;
        case (mode)
            SIPC_NORMAL: begin
                if (clk_sub) begin
                    next_mode = SIPC_SUBCLK;
                end
            end
            SIPC_SUBCLK: begin
                if (trig && !idle_kind) begin
                    next_mode = SIPC_SUB_IDLE;
                end else if (!clk_sub) begin
                    next_mode = SIPC_NORMAL;
                end
            end
            SIPC_SUB_IDLE: begin
                // reset path back to normal is the async reset itself
                if (wake) begin
                    next_mode = SIPC_SUBCLK;
                end
            end
            default: begin
                next_mode = SIPC_NORMAL;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode <= SIPC_NORMAL;
        end else begin
            mode <= next_mode;
        end
    end

    // clock and retention outputs follow the next mode so they
    // change on the same edge as the mode itself

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            CPU_CLK_EN_OUT <= 1'h1;
            RAM_HOLD_OUT <= 1'h0;
            SYS_CLK_SUB_OUT <= 1'h0;
            MODE_OUT <= SIPC_NORMAL;
        end else begin
            CPU_CLK_EN_OUT <= next_mode != SIPC_SUB_IDLE;
            RAM_HOLD_OUT <= next_mode == SIPC_SUB_IDLE;
            SYS_CLK_SUB_OUT <= next_mode != SIPC_NORMAL;
            MODE_OUT <= next_mode;
        end
    end

    // oscillator keeps running in idle; only the stop bit halts it
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MAIN_OSC_EN_OUT <= 1'h1;
        end else begin
            MAIN_OSC_EN_OUT <= !osc_stop;
        end
    end

    sipc_gate u_gate (
        .clk_in      (CLK_IN),
        .resetn_in   (RESETN_IN),
        .mode_in     (mode),
        .main_run_in (MAIN_OSC_EN_OUT),
        .src_in      (src),
        .en_out      (PERIPH_EN_OUT)
    );

    // checks

    sequence trig_ok_s;
        trig && !idle_kind && mode == SIPC_SUBCLK;
    endsequence

    sequence idle_two_s;
        mode == SIPC_SUB_IDLE [*2];
    endsequence

    sequence normal_three_s;
        mode == SIPC_NORMAL [*3];
    endsequence

    bus_answer_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(req) |-> ##1 !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
        else $error("bus answer not one cycle after request");

    idle_entry_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        trig_ok_s |=> mode == SIPC_SUB_IDLE && !CPU_CLK_EN_OUT
        && RAM_HOLD_OUT)
        else $error("idle not entered after trigger");

    idle_guard_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (mode == SIPC_NORMAL || (mode == SIPC_SUBCLK && idle_kind))
        |=> mode != SIPC_SUB_IDLE)
        else $error("idle entered outside subclock mode");

    idle_clock_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        mode == SIPC_SUB_IDLE |-> !CPU_CLK_EN_OUT && SYS_CLK_SUB_OUT
        && $stable(MAIN_OSC_EN_OUT))
        else $error("clocks wrong in idle");

    state_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        mode == SIPC_SUB_IDLE && wr_take |=> $stable(clk_sub)
        && $stable(osc_stop) && $stable(src) && $stable(idle_kind))
        else $error("state changed while idle");

    idle_periph_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        idle_two_s |-> !PERIPH_EN_OUT[`SIPC_P_PULSE]
        && !PERIPH_EN_OUT[`SIPC_P_ADC] && !PERIPH_EN_OUT[`SIPC_P_IRQ])
        else $error("main clock peripheral runs in idle");

    osc_stop_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        normal_three_s |-> MAIN_OSC_EN_OUT && !SYS_CLK_SUB_OUT)
        else $error("main osc stopped in normal mode");

    wake_resume_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        mode == SIPC_SUB_IDLE && wake |=> mode == SIPC_SUBCLK
        && CPU_CLK_EN_OUT && !RAM_HOLD_OUT)
        else $error("wake did not resume subclock mode");
endmodule

`default_nettype wire

// *** test_subclock_idle_power_control.sv ***
// self-checking bench for the subclock idle power controller
`default_nettype none
`include "sipc_defs.svh"

module test_subclock_idle_power_control;
    timeunit 1ns;
    timeprecision 1ns;

    logic                CLK_IN            = 1'b0;
    logic                RESETN_IN         = 1'b0;
    logic [`SIPC_AW-1:0] AVS_ADDRESS_IN    = 8'h00;
    logic                AVS_READ_IN       = 1'b0;
    logic                AVS_WRITE_IN      = 1'b0;
    logic [`SIPC_DW-1:0] AVS_WRITEDATA_IN  = 32'h0000_0000;
    logic [3:0]          AVS_BYTEENABLE_IN = 4'hf;
    logic [7:0]          WAKE_REQ_IN       = 8'h00;
    logic [`SIPC_DW-1:0] AVS_READDATA_OUT;
    logic                AVS_WAITREQUEST_OUT;
    logic                CPU_CLK_EN_OUT;
    logic                SYS_CLK_SUB_OUT;
    logic                MAIN_OSC_EN_OUT;
    logic                RAM_HOLD_OUT;
    logic [`SIPC_NP-1:0] PERIPH_EN_OUT;
    logic [1:0]          MODE_OUT;
    int                  fails        = 0;
    int                  total_checks = 0;

    always #25 CLK_IN = ~CLK_IN;

    sipc_top #(.WAKE_SRCS(8)) sipc_top_inst (
        .CLK_IN              (CLK_IN),
        .RESETN_IN           (RESETN_IN),
        .AVS_ADDRESS_IN      (AVS_ADDRESS_IN),
        .AVS_READ_IN         (AVS_READ_IN),
        .AVS_WRITE_IN        (AVS_WRITE_IN),
        .AVS_WRITEDATA_IN    (AVS_WRITEDATA_IN),
        .AVS_BYTEENABLE_IN   (AVS_BYTEENABLE_IN),
        .WAKE_REQ_IN         (WAKE_REQ_IN),
        .AVS_READDATA_OUT    (AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT (AVS_WAITREQUEST_OUT),
        .CPU_CLK_EN_OUT      (CPU_CLK_EN_OUT),
        .SYS_CLK_SUB_OUT     (SYS_CLK_SUB_OUT),
        .MAIN_OSC_EN_OUT     (MAIN_OSC_EN_OUT),
        .RAM_HOLD_OUT        (RAM_HOLD_OUT),
        .PERIPH_EN_OUT       (PERIPH_EN_OUT),
        .MODE_OUT            (MODE_OUT)
    );

    task automatic results;
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected enables; idle with main running is not modelled here
    function automatic logic [17:0] exp_en(input logic [1:0] m,
                                           input logic main_on,
                                           input logic [12:0] s);
        logic [17:0] e;
        logic        t16;
        if (m == 2'h0) begin
            return 18'h3_ffff;
        end
        if (main_on) begin
            return 18'h3_feff;
        end
        t16 = s[`SIPC_S_T16W] & s[`SIPC_S_WSUB];
        e = 18'h0_0000;
        e[`SIPC_P_IRQ]   = (m == 2'h1);
        e[`SIPC_P_T16]   = t16;
        e[`SIPC_P_T8A]   = s[`SIPC_S_T8A_EXT] | (s[`SIPC_S_T8A_T16] & t16);
        e[`SIPC_P_T8B]   = s[`SIPC_S_T8B_EXT] | (s[`SIPC_S_T8B_T16] & t16);
        e[`SIPC_P_HLDB]  = s[`SIPC_S_HLDB];
        e[`SIPC_P_WATCH] = s[`SIPC_S_WSUB];
        e[`SIPC_P_WDT2]  = s[`SIPC_S_WDT2];
        e[`SIPC_P_CSIA]  = s[`SIPC_S_CSIA];
        e[`SIPC_P_CSIB]  = s[`SIPC_S_CSIB];
        e[`SIPC_P_UARTA] = s[`SIPC_S_UARTA];
        e[`SIPC_P_KEY]   = 1'b1;
        e[`SIPC_P_RTO]   = s[`SIPC_S_RTOTRG] & (s[`SIPC_S_RTOSEL] ?
                           s[`SIPC_S_T8B_EXT] : s[`SIPC_S_T8A_EXT]);
        return e;
    endfunction

    // request held until waitrequest is sampled low
    task automatic bus_cycle(input logic [7:0] a, input logic wr,
                             input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CLK_IN);
        AVS_ADDRESS_IN   <= a;
        AVS_WRITEDATA_IN <= d;
        AVS_WRITE_IN     <= wr;
        AVS_READ_IN      <= !wr;
        do begin
            @(posedge CLK_IN);
            n++;
        end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 20);
        q = AVS_READDATA_OUT;
        AVS_WRITE_IN <= 1'b0;
        AVS_READ_IN  <= 1'b0;
        if (n >= 20) begin
            fails++;
            $display("ERROR bus answer expected 0 seen 1");
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(a, 1'b1, d, q);
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_cycle(a, 1'b0, 32'h0000_0000, q);
        check("read data", q, e);
    endtask

    // mode, enable and oscillator outputs lag by at most two edges
    task automatic settle;
        repeat (3) @(posedge CLK_IN);
    endtask

    task automatic check_state(input logic [1:0] m, input logic stop,
                               input logic [12:0] s);
        check("mode", MODE_OUT, m);
        check("cpu clock", CPU_CLK_EN_OUT, m != 2'h2);
        check("ram hold", RAM_HOLD_OUT, m == 2'h2);
        check("sub clock", SYS_CLK_SUB_OUT, m != 2'h0);
        check("main osc", MAIN_OSC_EN_OUT, !stop);
        check("periph en", PERIPH_EN_OUT, exp_en(m, !stop, s));
    endtask

    initial begin
        repeat (20000) @(posedge CLK_IN);
        fails++;
        results();
    end

    initial begin
        int          i;
        logic [12:0] s;
        logic [7:0]  w;
        void'($urandom(17));
        repeat (20) @(posedge CLK_IN);
        RESETN_IN <= 1'b1;
        settle();
        check_state(2'h0, 1'b0, 13'h0000);
        read_check(`SIPC_OFF_CLK, 32'h0000_0000);
        read_check(`SIPC_OFF_SRC, 32'h0000_0000);
        // idle trigger outside subclock mode has no effect
        bus_write(`SIPC_OFF_CTRL, 32'h0000_0001);
        settle();
        check_state(2'h0, 1'b0, 13'h0000);
        // stop without subclock selected is refused
        bus_write(`SIPC_OFF_CLK, 32'h0000_0002);
        settle();
        check_state(2'h0, 1'b0, 13'h0000);
        bus_write(`SIPC_OFF_CLK, 32'h0000_0001);
        settle();
        check_state(2'h1, 1'b0, 13'h0000);
        bus_write(`SIPC_OFF_MODE, 32'h0000_0001);
        bus_write(`SIPC_OFF_CTRL, 32'h0000_0001);
        settle();
        check_state(2'h1, 1'b0, 13'h0000);
        bus_write(`SIPC_OFF_MODE, 32'h0000_0000);
        bus_write(`SIPC_OFF_CLK, 32'h0000_0003);
        for (i = 0; i < 24; i++) begin
            s = (i == 0) ? 13'h1fff : (i == 1) ? 13'h0000 : 13'($urandom);
            bus_write(`SIPC_OFF_SRC, {19'h0_0000, s});
            settle();
            check_state(2'h1, 1'b1, s);
            read_check(`SIPC_OFF_STAT, {6'h00, exp_en(2'h1, 1'b0, s),
                                        8'h01});
            bus_write(`SIPC_OFF_CTRL, 32'h0000_0001);
            repeat (5) @(posedge CLK_IN);
            check_state(2'h2, 1'b1, s);
            // writes during idle are answered but leave state alone
            bus_write(`SIPC_OFF_SRC, {19'h0_0000, ~s});
            bus_write(`SIPC_OFF_CLK, 32'h0000_0000);
            settle();
            check_state(2'h2, 1'b1, s);
            w = 8'($urandom);
            WAKE_REQ_IN <= (w == 8'h00) ? 8'h80 : w;
            repeat (2) @(posedge CLK_IN);
            WAKE_REQ_IN <= 8'h00;
            check("wake mode", MODE_OUT, 2'h1);
            settle();
            check_state(2'h1, 1'b1, s);
            read_check(`SIPC_OFF_SRC, {19'h0_0000, s});
        end
        bus_write(`SIPC_OFF_CLK, 32'h0000_0001);
        settle();
        check_state(2'h1, 1'b0, s);
        bus_write(`SIPC_OFF_CTRL, 32'h0000_0001);
        settle();
        check("idle main on", MODE_OUT, 2'h2);
        WAKE_REQ_IN <= 8'h01;
        repeat (2) @(posedge CLK_IN);
        WAKE_REQ_IN <= 8'h00;
        check("wake main on", MODE_OUT, 2'h1);
        bus_write(`SIPC_OFF_CLK, 32'h0000_0000);
        settle();
        check_state(2'h0, 1'b0, s);
        // unmapped place reads zero and ignores writes
        bus_write(8'hfc, 32'hffff_ffff);
        read_check(8'hfc, 32'h0000_0000);
        // reset while idle returns to normal mode
        bus_write(`SIPC_OFF_CLK, 32'h0000_0003);
        bus_write(`SIPC_OFF_CTRL, 32'h0000_0001);
        settle();
        check("idle again", MODE_OUT, 2'h2);
        RESETN_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        check("reset mode", MODE_OUT, 2'h0);
        check("reset wait", AVS_WAITREQUEST_OUT, 1'b1);
        check("reset periph", PERIPH_EN_OUT, 18'h0_0000);
        RESETN_IN <= 1'b1;
        settle();
        check_state(2'h0, 1'b0, 13'h0000);
        read_check(`SIPC_OFF_CLK, 32'h0000_0000);
        results();
    end
endmodule

`default_nettype wire
